// File: core/adc_scan_consts.vh
`ifndef ADC_SCAN_CONSTS_VH
`define ADC_SCAN_CONSTS_VH

// Register indices; the bus byte address is four times the index.
`define IDX_MODE      16'hF800
`define IDX_CTRL      16'hF802
`define IDX_INTERVAL  16'hF804
`define IDX_REFSEL    16'hF806
`define IDX_IRQMODE   16'hF808
`define IDX_TRIGSEL   16'hF80A
`define IDX_ENLOW     16'hF80C
`define IDX_ENTEST    16'hF80E
`define IDX_LIMMODE   16'hF820
`define IDX_UPPER     16'hF822
`define IDX_LOWER     16'hF824
`define IDX_LIMSTAT   16'hF826
`define IDX_LIMCLR    16'hF82A
`define IDX_TESTMODE  16'hF830
`define IDX_LATEST    16'hF83E
`define IDX_RES_BLOCK 11'h7C2

// Reset values and the mode write mask.
`define RST_ZERO16    16'h0000
`define RST_UPPER     12'hFFF
`define MODE_WMASK    16'hF9FF

// Field positions.
`define RUN_BIT       0
`define TRGEN_BIT     1
`define SCAN_BIT      0
`define CKS_MSB       3
`define CKS_LSB       1
`define SHT_MSB       8
`define SHT_LSB       4
`define VREF_BIT      4
`define TCH_BIT       1
`define LEN_BIT       0
`define LMD_MSB       9
`define LMD_LSB       8

// Codes and timing.
`define CKS_LOWSPEED  3'h7
`define LMD_INSIDE    2'h0
`define LMD_ABOVE     2'h1
`define LMD_OUTSIDE   2'h2
`define CONV_EXTRA    6'h0F
`define TEST_SLOT     5'h10
`define TEST_CHAN     5'h11
`define NO_SLOT       5'h1F

`endif

// File: core/result_store.v
`timescale 1ns/1ns
`default_nettype none

module result_store #(
  parameter W  = 16,
  parameter AW = 4
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [W-1:0]  wdata,
  input  wire [AW-1:0] raddr,
  output reg  [W-1:0]  rdata
);
  reg [W-1:0] mem [0:(1<<AW)-1];
  integer     i;

  // Cleared at reset so every result register reads zero initially.
  always @(posedge clk) begin
    if (!rst_n) begin
      for (i = 0; i < (1 << AW); i = i + 1) begin
        mem[i] <= {W{1'b0}};
      end
      rdata <= {W{1'b0}};
    end else begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule

`default_nettype wire

// File: core/conv_tick_gen.v
`timescale 1ns/1ns
`default_nettype none
`include "adc_scan_consts.vh"

module conv_tick_gen (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [2:0] sel,
  input  wire       ls_tick,
  output wire       tick
);
  reg  [3:0] div_ff;

  function [3:0] div_mask;
    input [2:0] s;
    begin
      case (s)
        3'h0:    div_mask = 4'h0;
        3'h1:    div_mask = 4'h1;
        3'h2:    div_mask = 4'h3;
        3'h3:    div_mask = 4'h7;
        default: div_mask = 4'hF;
      endcase
    end
  endfunction

  always @(posedge clk) begin
    if (!rst_n) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end

  // divided fast clock or undivided slow clock
  assign tick = (sel == `CKS_LOWSPEED) ? ls_tick :
                ((div_ff & div_mask(sel)) == div_mask(sel));
endmodule

`default_nettype wire

// File: core/sar_adc_scan_controller.v
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "adc_scan_consts.vh"

module sar_adc_scan_controller (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        CYC_I,
  input  wire        STB_I,
  input  wire        WE_I,
  input  wire [17:0] ADR_I,
  input  wire [3:0]  SEL_I,
  input  wire [31:0] DAT_I,
  output wire [31:0] DAT_O,
  output wire        ACK_O,
  input  wire [6:0]  TRIG_IN,
  input  wire        LS_TICK,
  input  wire [11:0] ADC_RESULT,
  output wire        ADC_BUSY,
  output wire [4:0]  ADC_CHAN,
  output wire        ADC_VREF_EXT,
  output wire [1:0]  ADC_TEST_SEL,
  output wire        ADC_IRQ,
  output wire        STOP_INHIBIT
);
  localparam S_IDLE = 3'b001;
  localparam S_CONV = 3'b010;
  localparam S_GAP  = 3'b100;

  reg  [15:0] mode_ff;
  reg         run_ff;
  reg         trgen_ff;
  reg  [15:0] interval_ff;
  reg         vref_ff;
  reg  [1:0]  irqmode_ff;
  reg  [3:0]  trigsel_ff;
  reg  [15:0] enlow_ff;
  reg         entest_ff;
  reg         limen_ff;
  reg  [1:0]  limcond_ff;
  reg  [11:0] upper_ff;
  reg  [11:0] lower_ff;
  reg  [15:0] limstat_ff;
  reg  [1:0]  testmode_ff;
  reg  [15:0] latest_ff;
  reg         pend_ff;
  reg         ack_ff;
  reg  [31:0] dat_ff;
  reg  [2:0]  state_ff;
  reg  [4:0]  slot_ff;
  reg  [4:0]  chan_ff;
  reg  [5:0]  cnt_ff;
  reg  [15:0] gap_ff;
  reg         irq_ff;

  reg  [2:0]  nxt_state;
  reg  [4:0]  nxt_slot;
  reg  [5:0]  nxt_cnt;
  reg  [15:0] nxt_gap;
  reg         conv_done;
  reg         scan_end;
  reg  [15:0] rd_mux;

  wire        req;
  wire [15:0] idx;
  wire        wr_now;
  wire [15:0] wv;
  wire        is_res;
  wire [15:0] res_word;
  wire        ck_tick;
  wire [16:0] chmask;
  wire        any_en;
  wire        trig_hit;
  wire        single_mode;
  wire [5:0]  conv_len;
  wire [4:0]  first_slot;
  wire [4:0]  after_slot;
  wire        done_real;
  wire        hit;
  wire [15:0] set_bits;
  wire [15:0] clr_bits;
  wire [15:0] nxt_limstat;
  wire        per_chan_irq;
  wire        end_irq;
  wire        nxt_irq;
  wire        sw_start;
  wire        sw_stop;
  wire        hw_start;

  function [15:0] lanes;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  be;
    begin
      lanes = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // Lowest enabled slot at or above the given one; NO_SLOT when none.
  function [4:0] next_slot;
    input [16:0] m;
    input [4:0]  from;
    integer      i;
    begin
      next_slot = `NO_SLOT;
      for (i = 16; i >= 0; i = i - 1) begin
        if (m[i] && (i >= from)) begin
          next_slot = i[4:0];
        end
      end
    end
  endfunction

  function limit_match;
    input [11:0] r;
    input [11:0] up;
    input [11:0] lo;
    input [1:0]  c;
    begin
      case (c)
        `LMD_INSIDE:  limit_match = (r >= lo) && (r <= up);
        `LMD_ABOVE:   limit_match = (r > up);
        `LMD_OUTSIDE: limit_match = (r > up) || (r < lo);
        default:      limit_match = 1'b0;
      endcase
    end
  endfunction

  // source codes, reserved codes never fire
  function trig_pick;
    input [3:0] s;
    input [6:0] t;
    begin
      case (s)
        4'h0:    trig_pick = t[0];
        4'h1:    trig_pick = t[1];
        4'h2:    trig_pick = t[2];
        4'h4:    trig_pick = t[3];
        4'h5:    trig_pick = t[4];
        4'h8:    trig_pick = t[5];
        4'h9:    trig_pick = t[6];
        default: trig_pick = 1'b0;
      endcase
    end
  endfunction

  assign req    = CYC_I & STB_I;
  assign idx    = ADR_I[17:2];
  assign wr_now = req & WE_I & ack_ff;
  assign is_res = (idx[15:5] == `IDX_RES_BLOCK) & ~idx[0];
  assign wv     = lanes(rd_mux, DAT_I[15:0], SEL_I[1:0]);

  conv_tick_gen u_tick (
    .clk     (CLK),
    .rst_n   (RST_N),
    .sel     (mode_ff[`CKS_MSB:`CKS_LSB]),
    .ls_tick (LS_TICK),
    .tick    (ck_tick)
  );

  wire [15:0] mem_rdata;

  result_store #(.W(16), .AW(4)) u_res (
    .clk   (CLK),
    .rst_n (RST_N),
    .we    (conv_done & ~slot_ff[4]),
    .waddr (slot_ff[3:0]),
    .wdata (res_word),
    .raddr (idx[4:1]),
    .rdata (mem_rdata)
  );

  always @* begin
    rd_mux = 16'h0000;
    case (idx)
      `IDX_MODE:     rd_mux = mode_ff;
      `IDX_CTRL:     rd_mux = {14'h0000, trgen_ff, run_ff};
      `IDX_INTERVAL: rd_mux = interval_ff;
      `IDX_REFSEL:   rd_mux = {11'h000, vref_ff, 4'h0};
      `IDX_IRQMODE:  rd_mux = {14'h0000, irqmode_ff};
      `IDX_TRIGSEL:  rd_mux = {12'h000, trigsel_ff};
      `IDX_ENLOW:    rd_mux = enlow_ff;
      `IDX_ENTEST:   rd_mux = {14'h0000, entest_ff, 1'b0};
      `IDX_LIMMODE:  rd_mux = {6'h00, limcond_ff, 7'h00, limen_ff};
      `IDX_UPPER:    rd_mux = {upper_ff, 4'h0};
      `IDX_LOWER:    rd_mux = {lower_ff, 4'h0};
      `IDX_LIMSTAT:  rd_mux = limstat_ff;
      `IDX_TESTMODE: rd_mux = {14'h0000, testmode_ff};
      `IDX_LATEST:   rd_mux = latest_ff;
      default: begin
        if (is_res) begin
          rd_mux = mem_rdata;
        end
      end
    endcase
  end

  // Two-cycle answer: the result store needs one cycle to read.
  always @(posedge CLK) begin
    if (!RST_N) begin
      pend_ff <= 1'b0;
      ack_ff  <= 1'b0;
      dat_ff  <= 32'h00000000;
    end else begin
      pend_ff <= req & ~pend_ff & ~ack_ff;
      ack_ff  <= req & pend_ff;
      if (req & pend_ff) begin
        dat_ff <= {16'h0000, rd_mux};
      end
    end
  end

  assign chmask      = {entest_ff, enlow_ff};
  assign any_en      = |chmask;
  assign single_mode = ~mode_ff[`SCAN_BIT];
  assign trig_hit    = trig_pick(trigsel_ff, TRIG_IN);
  assign first_slot  = next_slot(chmask, 5'h00);
  assign after_slot  = next_slot(chmask, slot_ff + 5'h01);
  // sampling setting plus fixed conversion cycles
  assign conv_len    = {1'b0, mode_ff[`SHT_MSB:`SHT_LSB]} + `CONV_EXTRA;

  always @* begin
    nxt_state = state_ff;
    nxt_slot  = slot_ff;
    nxt_cnt   = cnt_ff;
    nxt_gap   = gap_ff;
    conv_done = 1'b0;
    scan_end  = 1'b0;
    case (state_ff)
      S_IDLE: begin
        // start waits for the next converter clock tick
        if (run_ff & ck_tick & (first_slot != `NO_SLOT)) begin
          nxt_state = S_CONV;
          nxt_slot  = first_slot;
          nxt_cnt   = 6'h00;
        end
      end
      S_CONV: begin
        if (!run_ff) begin
          nxt_state = S_IDLE;
        end else if (ck_tick) begin
          nxt_cnt = cnt_ff + 6'h01;
          if (nxt_cnt >= conv_len) begin
            conv_done = 1'b1;
            nxt_cnt   = 6'h00;
            if (after_slot != `NO_SLOT) begin
              nxt_slot = after_slot;
            end else begin
              scan_end = 1'b1;
              // consecutive mode goes on to the gap
              nxt_state = single_mode ? S_IDLE : S_GAP;
              nxt_gap   = 16'h0000;
            end
          end
        end
      end
      S_GAP: begin
        if (!run_ff) begin
          nxt_state = S_IDLE;
        end else if (ck_tick) begin
          if (({1'b0, gap_ff} + 17'h00001) >= {1'b0, interval_ff}) begin
            nxt_state = (first_slot != `NO_SLOT) ? S_CONV : S_IDLE;
            nxt_slot  = first_slot;
            nxt_cnt   = 6'h00;
          end else begin
            nxt_gap = gap_ff + 16'h0001;
          end
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      state_ff <= S_IDLE;
      slot_ff  <= 5'h00;
      chan_ff  <= 5'h00;
      cnt_ff   <= 6'h00;
      gap_ff   <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      slot_ff  <= nxt_slot;
      // test slot converts as channel 17
      chan_ff  <= (nxt_slot == `TEST_SLOT) ? `TEST_CHAN : nxt_slot;
      cnt_ff   <= nxt_cnt;
      gap_ff   <= nxt_gap;
    end
  end

  assign res_word  = {ADC_RESULT, 4'h0};
  assign done_real = conv_done & ~slot_ff[4];
  assign hit       = limit_match(ADC_RESULT, upper_ff, lower_ff, limcond_ff);
  // set the converted channel's match flag
  // only while limit checking is enabled
  assign set_bits  = (limen_ff & done_real & hit) ? (16'h0001 << slot_ff[3:0])
                                                  : 16'h0000;
  // write one clears, zero leaves alone
  assign clr_bits  = (wr_now && (idx == `IDX_LIMCLR)) ? wv : 16'h0000;
  // set wins over a clear in the same cycle
  assign nxt_limstat = (limstat_ff & ~clr_bits) | set_bits;

  // per channel or at scan end
  assign per_chan_irq = irqmode_ff[0] & conv_done;
  assign end_irq      = ~irqmode_ff[0] & scan_end;
  // match-only unless mode bit one is set or limit checking is off
  // scan end fires when any status bit is one
  assign nxt_irq = (~limen_ff | irqmode_ff[1]) ? (per_chan_irq | end_irq) :
                   ((per_chan_irq & (|set_bits)) | (end_irq & (|nxt_limstat)));

  assign sw_start = wr_now && (idx == `IDX_CTRL) && SEL_I[0] && wv[`RUN_BIT];
  assign sw_stop  = wr_now && (idx == `IDX_CTRL) && SEL_I[0] && !wv[`RUN_BIT];
  assign hw_start = trgen_ff & trig_hit & (state_ff == S_IDLE);

  always @(posedge CLK) begin
    if (!RST_N) begin
      run_ff     <= 1'b0;
      limstat_ff <= `RST_ZERO16;
      latest_ff  <= `RST_ZERO16;
      irq_ff     <= 1'b0;
    end else begin
      // no enabled channel keeps run at zero
      if (sw_stop) begin
        run_ff <= 1'b0;
      end else if ((sw_start | hw_start) & any_en) begin
        run_ff <= 1'b1;
      end else if (scan_end & single_mode) begin
        // single scan ends by clearing run
        run_ff <= 1'b0;
      end else if ((state_ff == S_GAP) & ck_tick & (first_slot == `NO_SLOT)) begin
        run_ff <= 1'b0;
      end
      limstat_ff <= nxt_limstat;
      if (conv_done) begin
        latest_ff <= res_word;
      end
      irq_ff <= nxt_irq;
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      mode_ff     <= `RST_ZERO16;
      trgen_ff    <= 1'b0;
      interval_ff <= `RST_ZERO16;
      vref_ff     <= 1'b0;
      irqmode_ff  <= 2'h0;
      trigsel_ff  <= 4'h0;
      enlow_ff    <= `RST_ZERO16;
      entest_ff   <= 1'b0;
      limen_ff    <= 1'b0;
      limcond_ff  <= 2'h0;
      upper_ff    <= `RST_UPPER;
      lower_ff    <= 12'h000;
      testmode_ff <= 2'h0;
    end else if (wr_now) begin
      case (idx)
        `IDX_MODE:     mode_ff     <= wv & `MODE_WMASK;
        `IDX_CTRL:     trgen_ff    <= wv[`TRGEN_BIT];
        `IDX_INTERVAL: interval_ff <= wv;
        `IDX_REFSEL:   vref_ff     <= wv[`VREF_BIT];
        `IDX_IRQMODE:  irqmode_ff  <= wv[1:0];
        `IDX_TRIGSEL:  trigsel_ff  <= wv[3:0];
        `IDX_ENLOW:    enlow_ff    <= wv;
        `IDX_ENTEST:   entest_ff   <= wv[`TCH_BIT];
        `IDX_LIMMODE: begin
          limen_ff   <= wv[`LEN_BIT];
          limcond_ff <= wv[`LMD_MSB:`LMD_LSB];
        end
        // twelve-bit thresholds in the high bits
        `IDX_UPPER:    upper_ff    <= wv[15:4];
        `IDX_LOWER:    lower_ff    <= wv[15:4];
        `IDX_TESTMODE: testmode_ff <= wv[1:0];
        default: begin
          trgen_ff <= trgen_ff;
        end
      endcase
    end
  end

  assign DAT_O        = dat_ff;
  assign ACK_O        = ack_ff;
  assign ADC_BUSY     = state_ff[1];
  assign ADC_CHAN     = chan_ff;
  assign ADC_VREF_EXT = vref_ff;
  assign ADC_TEST_SEL = testmode_ff;
  assign ADC_IRQ      = irq_ff;
  assign STOP_INHIBIT = run_ff;
endmodule

`default_nettype wire

// File: test/adc_scan_checker_sva.sv
`timescale 1ns/1ns
`default_nettype none
module adc_scan_checker (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       ADC_BUSY,
  input wire logic [4:0] ADC_CHAN,
  input wire logic       ADC_IRQ,
  input wire logic       STOP_INHIBIT
);
  logic [7:0] hold_ff;
  logic [4:0] chan_ff;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Counts cycles spent on one channel, to bound the conversion length.
  always @(posedge CLK) begin
    chan_ff <= ADC_CHAN;
    if (!RST_N || !ADC_BUSY || ADC_CHAN != chan_ff) begin
      hold_ff <= 8'h00;
    end else if (hold_ff != 8'hFF) begin
      hold_ff <= hold_ff + 8'h01;
    end
  end
  property p_run_first;
    $rose(ADC_BUSY) |-> STOP_INHIBIT;
  endproperty
  a_run_first: assert property (p_run_first) else $error("busy rose without run");
  property p_idle;
    !STOP_INHIBIT && !$past(STOP_INHIBIT) |-> !ADC_BUSY;
  endproperty
  a_idle: assert property (p_idle) else $error("busy while stopped");
  property p_order;
    ADC_BUSY && $past(ADC_BUSY) && ADC_CHAN != $past(ADC_CHAN) |-> ADC_CHAN > $past(ADC_CHAN);
  endproperty
  a_order: assert property (p_order) else $error("channel order descends");
  property p_chan_len;
    ADC_BUSY && $past(ADC_BUSY) && ADC_CHAN != $past(ADC_CHAN) |-> hold_ff >= 8'h0E;
  endproperty
  a_chan_len: assert property (p_chan_len) else $error("channel too short");
  property p_test;
    ADC_BUSY && ADC_CHAN > 5'h0F |-> ADC_CHAN == 5'h11;
  endproperty
  a_test: assert property (p_test) else $error("bad channel number");
  property p_auto_clear;
    $fell(STOP_INHIBIT) |-> ##[0:1] !ADC_BUSY;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("busy after run cleared");
  property p_gap;
    $fell(ADC_BUSY) && STOP_INHIBIT |=> !ADC_BUSY;
  endproperty
  a_gap: assert property (p_gap) else $error("no gap between scans");
  property p_irq_pulse;
    ADC_IRQ |=> !ADC_IRQ;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a cycle");
  property p_irq_cause;
    ADC_IRQ |-> $past(ADC_BUSY) || $past(ADC_BUSY, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without conversion");
  c_irq: cover property (ADC_IRQ);
  c_test: cover property (ADC_BUSY && ADC_CHAN == 5'h11);
  c_gap: cover property ($fell(ADC_BUSY) && STOP_INHIBIT);
endmodule
bind sar_adc_scan_controller adc_scan_checker u_chk (
  .CLK(CLK), .RST_N(RST_N), .ADC_BUSY(ADC_BUSY), .ADC_CHAN(ADC_CHAN),
  .ADC_IRQ(ADC_IRQ), .STOP_INHIBIT(STOP_INHIBIT));
`default_nettype wire

// File: test/adc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module adc_core_model #(
  parameter int LS_DIV = 20
) (
  input  wire logic        clk,
  input  wire logic        busy,
  input  wire logic [4:0]  chan,
  input  wire logic [11:0] offset,
  output var  logic [11:0] result,
  output var  logic        ls_tick
);
  int          div_ff = 0;
  logic [11:0] pat_ff = 12'h5A5;
  // Outside a conversion the analog level is not held, so it toggles.
  assign result = busy ? offset + {3'h0, chan, 4'h0} : pat_ff;
  initial ls_tick = 1'b0;
  always @(posedge clk) begin
    pat_ff  <= ~pat_ff;
    ls_tick <= div_ff == LS_DIV - 1;
    div_ff  <= div_ff == LS_DIV - 1 ? 0 : div_ff + 1;
  end
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "adc_scan_consts.vh"
module testbench;
  localparam int LS = 20;
  logic        CLK = 1'b0, RST_N = 1'b0, CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
  logic [17:0] ADR_I = 18'h0;
  logic [3:0]  SEL_I = 4'h0;
  logic [31:0] DAT_I = 32'h0;
  logic [6:0]  TRIG_IN = 7'h0;
  logic [11:0] off = 12'h0;
  wire         ACK_O, LS_TICK, ADC_BUSY, ADC_VREF_EXT, ADC_IRQ, STOP_INHIBIT;
  wire  [31:0] DAT_O;
  wire  [11:0] ADC_RESULT;
  wire  [4:0]  ADC_CHAN;
  wire  [1:0]  ADC_TEST_SEL;
  logic [15:0] rd, en, up, lo, st;
  logic        seen_busy = 1'b0, seen_test = 1'b0;
  int          fail_count = 0, check_count = 0, cycles = 0, irqs = 0, n, d, s;
  logic [15:0] ridx [6] = '{`IDX_CTRL, `IDX_INTERVAL, `IDX_UPPER, `IDX_LOWER, `IDX_LIMSTAT, 16'hF810};
  logic [15:0] rval [6] = '{16'h0000, 16'h0000, 16'hFFF0, 16'h0000, 16'h0000, 16'h0000};
  logic [3:0]  tcode [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'h9};
  sar_adc_scan_controller DUT (
    .CLK(CLK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .TRIG_IN(TRIG_IN),
    .LS_TICK(LS_TICK), .ADC_RESULT(ADC_RESULT), .ADC_BUSY(ADC_BUSY), .ADC_CHAN(ADC_CHAN),
    .ADC_VREF_EXT(ADC_VREF_EXT), .ADC_TEST_SEL(ADC_TEST_SEL), .ADC_IRQ(ADC_IRQ),
    .STOP_INHIBIT(STOP_INHIBIT));
  adc_core_model #(.LS_DIV(LS)) u_core (.clk(CLK), .busy(ADC_BUSY), .chan(ADC_CHAN),
    .offset(off), .result(ADC_RESULT), .ls_tick(LS_TICK));
  initial forever #4 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (ADC_IRQ === 1'b1) irqs++;
    if (ADC_BUSY === 1'b1) seen_busy = 1'b1;
    if (ADC_BUSY === 1'b1 && ADC_CHAN === 5'h11) seen_test = 1'b1;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    check_count++;
    if (v !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic wb(input logic w, input logic [15:0] idx, input logic [15:0] dat);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I  <= w;
    ADR_I <= {idx, 2'b00};
    SEL_I <= 4'h3;
    DAT_I <= {16'h0, dat};
    do @(posedge CLK); while (ACK_O !== 1'b1);
    rd = DAT_O[15:0];
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rc(input logic [15:0] idx, input logic [15:0] e);
    wb(1'b0, idx, 16'h0);
    chk("register read", {16'h0, e}, {16'h0, rd});
  endtask
  task automatic scan(input logic [15:0] m, input logic [15:0] e);
    wb(1'b1, `IDX_MODE, m);
    wb(1'b1, `IDX_ENLOW, e);
    irqs = 0;
    wb(1'b1, `IDX_CTRL, 16'h0001);
    while (STOP_INHIBIT !== 1'b0) @(posedge CLK);
    repeat (2) @(posedge CLK);
  endtask
  function automatic logic [11:0] res(input int ch);
    res = off + 12'(ch * 16);
  endfunction
  function automatic logic [15:0] lim(input logic [15:0] e, input int c);
    logic [11:0] r;
    lim = 16'h0;
    for (int i = 0; i < 16; i++) begin
      r = res(i);
      if (e[i] && (c == 0 ? r >= lo[15:4] && r <= up[15:4] : r > up[15:4] || c == 2 && r < lo[15:4]))
        lim[i] = 1'b1;
    end
  endfunction
  initial begin
    void'($urandom(32'hD42AA58B));
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    foreach (ridx[i]) rc(ridx[i], rval[i]);
    wb(1'b1, `IDX_LOWER, 16'hFFFF);
    rc(`IDX_LOWER, 16'hFFF0);
    wb(1'b1, `IDX_CTRL, 16'h0001);
    rc(`IDX_CTRL, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      off <= 12'($urandom);
      en = 16'($urandom) | 16'h8001;
      up = k == 0 ? 16'hFFF0 : 16'($urandom) & 16'hFFF0;
      lo = k == 0 ? 16'h0000 : (up >> 1) & 16'hFFF0;
      wb(1'b1, `IDX_UPPER, up);
      wb(1'b1, `IDX_LOWER, lo);
      wb(1'b1, `IDX_LIMMODE, {6'h0, 2'(k), 7'h0, 1'b1});
      wb(1'b1, `IDX_IRQMODE, k == 2 ? 16'h0000 : 16'h0002 | 16'(k));
      scan(16'($urandom % 4) << 4, en);
      st = lim(en, k);
      rc(`IDX_LIMSTAT, st);
      chk("irq count", k == 1 ? $countones(en) : k == 0 || st != 0, irqs);
      for (int i = 0; i < 16; i++) if (en[i]) rc(16'hF840 + 16'(2 * i), {res(i), 4'h0});
      rc(`IDX_LATEST, {res(15), 4'h0});
      if (k == 2) begin
        wb(1'b1, `IDX_LIMMODE, 16'h0000);
        off <= ~off;
        scan(16'h0000, en);
        rc(`IDX_LIMSTAT, st);
      end
      wb(1'b1, `IDX_LIMCLR, 16'h0000);
      rc(`IDX_LIMSTAT, st);
      wb(1'b1, `IDX_LIMCLR, 16'hFFFF);
      rc(`IDX_LIMSTAT, 16'h0000);
    end
    wb(1'b1, `IDX_ENTEST, 16'h0002);
    wb(1'b1, `IDX_TESTMODE, 16'h0003);
    wb(1'b1, `IDX_REFSEL, 16'h0010);
    scan(16'h0000, 16'h0001);
    chk("test channel", 1, seen_test);
    rc(`IDX_LATEST, {res(17), 4'h0});
    chk("reference pin", 1, ADC_VREF_EXT);
    chk("test select", 3, ADC_TEST_SEL);
    wb(1'b1, `IDX_ENTEST, 16'h0000);
    foreach (tcode[j]) begin
      wb(1'b1, `IDX_TRIGSEL, {12'h0, tcode[j]});
      for (int g = 0; g < 3; g++) begin
        wb(1'b1, `IDX_CTRL, g == 2 ? 16'h0000 : 16'h0002);
        seen_busy = 1'b0;
        TRIG_IN <= 7'(1 << (g == 0 ? (j + 1) % 7 : j));
        @(posedge CLK);
        TRIG_IN <= 7'h0;
        repeat (40) @(posedge CLK);
        chk("trigger start", g == 1, seen_busy);
      end
    end
    wb(1'b1, `IDX_TRIGSEL, 16'h0003);
    wb(1'b1, `IDX_CTRL, 16'h0002);
    seen_busy = 1'b0;
    TRIG_IN <= 7'h7F;
    @(posedge CLK);
    TRIG_IN <= 7'h00;
    repeat (40) @(posedge CLK);
    chk("reserved trigger", 0, seen_busy);
    for (int c = 0; c < 6; c++) begin
      d = c == 5 ? LS : 1 << c;
      s = $urandom % 4;
      wb(1'b1, `IDX_MODE, 16'(s << 4 | (c == 5 ? 7 : c) << 1));
      wb(1'b1, `IDX_CTRL, 16'h0001);
      n = 0;
      while (ADC_BUSY !== 1'b1) begin
        @(posedge CLK);
        n++;
      end
      chk("start delay", 1, n <= (c == 5 ? 3 * LS : d + 2));
      n = 0;
      while (ADC_BUSY === 1'b1) begin
        @(posedge CLK);
        n++;
      end
      chk("conversion time", 1, n >= (s + 15) * d - 1 && n <= (s + 16) * d);
      repeat (4) @(posedge CLK);
    end
    d = 20 + $urandom % 20;
    wb(1'b1, `IDX_INTERVAL, 16'(d));
    wb(1'b1, `IDX_MODE, 16'h0001);
    wb(1'b1, `IDX_ENLOW, 16'h0003);
    wb(1'b1, `IDX_CTRL, 16'h0001);
    repeat (2) begin
      while (ADC_BUSY !== 1'b1) @(posedge CLK);
      while (ADC_BUSY === 1'b1) @(posedge CLK);
      n = 0;
      while (ADC_BUSY !== 1'b1) begin
        @(posedge CLK);
        n++;
      end
      chk("scan gap", 1, n >= d && n <= d + 3);
    end
    wb(1'b1, `IDX_CTRL, 16'h0000);
    @(posedge CLK);
    chk("stop", 0, {ADC_BUSY, STOP_INHIBIT});
    end_sim();
  end
endmodule
`default_nettype wire
